/* File: src/fdc_ctrl.sv */
// controller shell end: axi4-lite registers, fabric link target, memory side
`timescale 1ns/100ps
module fdc_ctrl #(
  parameter logic [31:0] MEM_BYTES = 32'h1000_0000,
  parameter int CAL_CYCLES = fdc_pkg::CAL_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  fdc_link_if.ctrl link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fabric_clock_locked_in,
  input wire logic clock_synth_locked,
  output logic [1:0] mem_type,
  output logic [1:0] mem_width,
  output logic mem_ecc_en,
  output logic mem_req,
  output logic mem_we,
  output logic [fdc_pkg::ADDR_W-1:0] mem_addr,
  output logic [fdc_pkg::DATA_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [fdc_pkg::DATA_W-1:0] mem_rdata,
  input wire logic mem_ecc_single,
  input wire logic mem_ecc_double,
  output logic [fdc_pkg::IRQ_N-1:0] irq_lines,
  output logic irq
);
  import fdc_pkg::*;

  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_MEM = 2'b01,
    LS_RSP = 2'b10
  } fdc_lstate_e;

  // merge a write into a register under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_have_ff, w_have_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [31:0] ctrl_ff, freq_ff, fab_ff;
  logic [IRQ_N-1:0] stat_ff, mask_ff, ev;
  logic [15:0] cal_cnt_ff;
  logic wr_go, rd_go;
  logic [31:0] wr_val;

  assign wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
  assign rd_go = s_axi_arvalid && arready_ff;

  // write channels taken in either order; one write in flight at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        aw_addr_ff <= s_axi_awaddr;
        aw_have_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        w_have_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (wr_go) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (aw_addr_ff > OFS_FREQ) ? RESP_SLVERR : RESP_OKAY; // fab reg is read-only
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // read channel; unmapped offsets answer slverr with zero data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (rd_go) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL: rdata_ff <= ctrl_ff;
        OFS_STAT: rdata_ff <= {27'h0, stat_ff};
        OFS_MASK: rdata_ff <= {27'h0, mask_ff};
        OFS_RECAL: rdata_ff <= {30'h0, clock_synth_locked, cal_cnt_ff != 16'h0000};
        OFS_FREQ: rdata_ff <= freq_ff;
        OFS_FAB: rdata_ff <= fab_ff;
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // configuration registers written before any memory access
  assign wr_val = merge(ctrl_ff, w_data_ff, w_strb_ff);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RST;
      mask_ff <= MASK_RST;
      freq_ff <= FREQ_RST_KHZ;
    end else if (wr_go) begin
      if (aw_addr_ff == OFS_CTRL) begin
        ctrl_ff <= wr_val; // memory type width ecc bus
      end
      if (aw_addr_ff == OFS_MASK) begin
        mask_ff <= w_data_ff[IRQ_N-1:0];
      end
      if (aw_addr_ff == OFS_FREQ) begin
        // out of range values clamp to the supported band
        if (w_data_ff < FREQ_MIN_KHZ) begin
          freq_ff <= FREQ_MIN_KHZ;
        end else if (w_data_ff > FREQ_MAX_KHZ) begin
          freq_ff <= FREQ_MAX_KHZ;
        end else begin
          freq_ff <= w_data_ff;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // fabric clock divisor
  // ----------------------------------------------------------------
  logic [3:0] div_eff, div_cnt_ff;
  logic tick_ff;
  assign div_eff = (ctrl_ff[CTL_DIV_LSB +: 4] == 4'h0) ? 4'h1 : ctrl_ff[CTL_DIV_LSB +: 4];

  // tick marks each fabric-side cycle; the link only moves on it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_ff <= 4'h0;
      tick_ff <= 1'b0;
      fab_ff <= 32'h0000_0000;
    end else begin
      div_cnt_ff <= (div_cnt_ff >= div_eff - 4'h1) ? 4'h0 : div_cnt_ff + 4'h1;
      tick_ff <= (div_cnt_ff >= div_eff - 4'h1);
      fab_ff <= freq_ff / {28'h0, div_eff}; // fabric rate readback
    end
  end

  // ----------------------------------------------------------------
  // fabric link target
  // ----------------------------------------------------------------
  fdc_lstate_e state_ff, nxt_state;
  logic hold, take, ready_ff, rsp_valid_ff, rsp_err_ff, rsp_port_ff;
  logic addr_bad, ahb_mode;
  logic [DATA_W-1:0] rsp_rdata_ff;
  logic mem_req_ff, mem_we_ff;
  logic [ADDR_W-1:0] mem_addr_ff;
  logic [DATA_W-1:0] mem_wdata_ff;

  // with lock checking enabled (CTL_LOCKEN), no request is taken while the fabric clock is unlocked
  assign hold = ctrl_ff[CTL_LOCKEN] && !fabric_clock_locked_in;
  assign take = tick_ff && ready_ff && link.req_valid;
  assign addr_bad = link.req_addr >= MEM_BYTES;
  assign ahb_mode = ctrl_ff[CTL_BUS_LSB +: 2] != FDC_AXI64;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      LS_IDLE: if (take) nxt_state = addr_bad ? LS_RSP : LS_MEM;
      LS_MEM: if (mem_ack) nxt_state = LS_RSP;
      LS_RSP: if (tick_ff) nxt_state = LS_IDLE;
      default: nxt_state = LS_IDLE;
    endcase
  end

  // each in-range fabric request becomes one memory access; never initiates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= LS_IDLE;
      ready_ff <= 1'b0;
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= '0;
      mem_wdata_ff <= '0;
      rsp_valid_ff <= 1'b0;
      rsp_err_ff <= 1'b0;
      rsp_port_ff <= 1'b0;
      rsp_rdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= (nxt_state == LS_IDLE) && !hold;
      if (tick_ff) begin
        rsp_valid_ff <= 1'b0;
      end
      if (state_ff == LS_IDLE && take) begin
        mem_we_ff <= link.req_write;
        mem_addr_ff <= link.req_addr;
        // ahb ports carry 32 bits only
        mem_wdata_ff <= ahb_mode ? {32'h0, link.req_wdata[31:0]} : link.req_wdata;
        rsp_port_ff <= link.req_port; // echoed in every mode so the asker finds it
        mem_req_ff <= !addr_bad;
        rsp_err_ff <= addr_bad;
        rsp_rdata_ff <= '0;
      end
      if (state_ff == LS_MEM && mem_ack) begin
        mem_req_ff <= 1'b0;
        rsp_err_ff <= ctrl_ff[CTL_ECC] && mem_ecc_double;
        rsp_rdata_ff <= ahb_mode ? {32'h0, mem_rdata[31:0]} : mem_rdata;
      end
      if (state_ff == LS_RSP && tick_ff) begin
        rsp_valid_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // recalibration, synth lock tracking, interrupts
  // ----------------------------------------------------------------
  logic lock_q_ff;
  logic [IRQ_N-1:0] irq_lines_ff;
  logic irq_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_cnt_ff <= 16'h0000;
      lock_q_ff <= 1'b0;
    end else begin
      lock_q_ff <= clock_synth_locked;
      if (wr_go && aw_addr_ff == OFS_RECAL && w_data_ff[RCL_START] && cal_cnt_ff == 16'h0000) begin
        cal_cnt_ff <= 16'(CAL_CYCLES);
      end else if (cal_cnt_ff != 16'h0000) begin
        cal_cnt_ff <= cal_cnt_ff - 16'h0001;
      end
    end
  end

  always_comb begin
    ev = '0;
    ev[IRQ_FAB] = state_ff == LS_RSP && tick_ff && rsp_err_ff;
    ev[IRQ_CAL] = cal_cnt_ff == 16'h0001;
    ev[IRQ_LOCK] = clock_synth_locked && !lock_q_ff;
    ev[IRQ_LOST] = !clock_synth_locked && lock_q_ff;
    ev[IRQ_ECC] = state_ff == LS_MEM && mem_ack && ctrl_ff[CTL_ECC]
                  && (mem_ecc_single || mem_ecc_double);
  end

  // sticky status; a read clears only what it returned, so a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= '0;
      irq_lines_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      stat_ff <= (stat_ff & ~((rd_go && s_axi_araddr == OFS_STAT) ? stat_ff : '0)) | ev;
      // outputs stay quiet unless interrupts are enabled
      irq_lines_ff <= ctrl_ff[CTL_IRQEN] ? (stat_ff & mask_ff) : '0;
      irq_ff <= ctrl_ff[CTL_IRQEN] && |(stat_ff & mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign mem_type = ctrl_ff[CTL_TYPE_LSB +: 2];
  assign mem_width = ctrl_ff[CTL_WIDTH_LSB +: 2];
  assign mem_ecc_en = ctrl_ff[CTL_ECC];
  assign mem_req = mem_req_ff;
  assign mem_we = mem_we_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign irq_lines = irq_lines_ff;
  assign irq = irq_ff;
  assign link.fic_tick = tick_ff;
  assign link.bus_mode = ctrl_ff[CTL_BUS_LSB +: 2];
  assign link.req_ready = ready_ff;
  assign link.rsp_valid = rsp_valid_ff;
  assign link.rsp_err = rsp_err_ff;
  assign link.rsp_port = rsp_port_ff;
  assign link.rsp_rdata = rsp_rdata_ff;

endmodule : fdc_ctrl

/* File: shared/fdc_pkg.sv */
// shared constants, types and register map of the fabric ddr controller shell
package fdc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int ADDR_W = 32;
  localparam int IRQ_N = 5;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_RECAL = 8'h0C;
  localparam logic [7:0] OFS_FREQ = 8'h10;
  localparam logic [7:0] OFS_FAB = 8'h14;

  // control register fields
  localparam int CTL_TYPE_LSB = 0;
  localparam int CTL_WIDTH_LSB = 2;
  localparam int CTL_ECC = 4;
  localparam int CTL_IRQEN = 5;
  localparam int CTL_LOCKEN = 6;
  localparam int CTL_DIV_LSB = 8;
  localparam int CTL_BUS_LSB = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_020A;

  // status and mask bit positions
  localparam int IRQ_FAB = 0;
  localparam int IRQ_CAL = 1;
  localparam int IRQ_LOCK = 2;
  localparam int IRQ_LOST = 3;
  localparam int IRQ_ECC = 4;
  localparam logic [IRQ_N-1:0] MASK_RST = 5'h00;

  // recal register bits
  localparam int RCL_START = 0;
  localparam int RCL_LOCKED = 1;

  // controller clock range in kHz
  localparam logic [31:0] FREQ_MIN_KHZ = 32'h0000_4E20;
  localparam logic [31:0] FREQ_MAX_KHZ = 32'h0005_14C8;
  localparam logic [31:0] FREQ_RST_KHZ = 32'h0003_0D40;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int CAL_TIME_NS = 2000;
  localparam int CAL_CYCLES = (CAL_TIME_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FDC_LPDDR = 2'b00,
    FDC_DDR2 = 2'b01,
    FDC_DDR3 = 2'b10
  } fdc_mem_e;

  typedef enum logic [1:0] {
    FDC_W8 = 2'b00,
    FDC_W16 = 2'b01,
    FDC_W32 = 2'b10
  } fdc_width_e;

  typedef enum logic [1:0] {
    FDC_AXI64 = 2'b00,
    FDC_AHB_ONE = 2'b01,
    FDC_AHB_TWO = 2'b10
  } fdc_bus_e;

endpackage : fdc_pkg

/* File: shared/fdc_link_if.sv */
// fabric-side link between the controller shell and a fabric initiator
`timescale 1ns/100ps
interface fdc_link_if #(
  parameter int DATA_W = 64,
  parameter int ADDR_W = 32
) (
  input wire logic aclk
);
  logic fic_tick;
  logic [1:0] bus_mode;
  logic req_valid;
  logic req_ready;
  logic req_write;
  logic req_port;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata;
  logic rsp_valid;
  logic rsp_err;
  logic rsp_port;
  logic [DATA_W-1:0] rsp_rdata;

  modport ctrl (
    input aclk, req_valid, req_write, req_port, req_addr, req_wdata,
    output fic_tick, bus_mode, req_ready, rsp_valid, rsp_err, rsp_port, rsp_rdata
  );

  modport init (
    input aclk, fic_tick, bus_mode, req_ready, rsp_valid, rsp_err, rsp_port, rsp_rdata,
    output req_valid, req_write, req_port, req_addr, req_wdata
  );
endinterface : fdc_link_if

/* File: src/fdc_initiator.sv */
// fabric initiator end: turns user commands into link requests on fabric ticks
`timescale 1ns/100ps
module fdc_initiator #(
  parameter logic PORT_ID = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  fdc_link_if.init link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [fdc_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [fdc_pkg::DATA_W-1:0] cmd_wdata,
  output logic done,
  output logic done_err,
  output logic [fdc_pkg::DATA_W-1:0] done_rdata
);
  import fdc_pkg::*;

  typedef enum logic [1:0] {
    IS_IDLE = 2'b00,
    IS_ARM = 2'b01,
    IS_TAKE = 2'b10,
    IS_RSP = 2'b11
  } fdc_istate_e;

  fdc_istate_e state_ff;
  logic ready_ff, done_ff, err_ff, valid_ff, write_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff, rdata_ff;
  logic ahb_mode;

  assign ahb_mode = link.bus_mode != FDC_AXI64;

  // ----------------------------------------------------------------
  // request sequencing; req_valid changes only at fabric ticks
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= IS_IDLE;
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      valid_ff <= 1'b0;
      write_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= '0;
      rdata_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        IS_IDLE: begin
          ready_ff <= 1'b1;
          if (cmd_valid && ready_ff) begin
            ready_ff <= 1'b0;
            write_ff <= cmd_write;
            addr_ff <= cmd_addr;
            // a 32-bit ahb initiator never drives the upper half
            wdata_ff <= ahb_mode ? {32'h0, cmd_wdata[31:0]} : cmd_wdata;
            state_ff <= IS_ARM;
          end
        end
        IS_ARM: if (link.fic_tick) begin
          valid_ff <= 1'b1;
          state_ff <= IS_TAKE;
        end
        IS_TAKE: if (link.fic_tick && link.req_ready) begin
          valid_ff <= 1'b0;
          state_ff <= IS_RSP;
        end
        IS_RSP: if (link.fic_tick && link.rsp_valid && link.rsp_port == PORT_ID) begin
          done_ff <= 1'b1;
          err_ff <= link.rsp_err;
          rdata_ff <= ahb_mode ? {32'h0, link.rsp_rdata[31:0]} : link.rsp_rdata;
          ready_ff <= 1'b1;
          state_ff <= IS_IDLE;
        end
        default: state_ff <= IS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmd_ready = ready_ff;
  assign done = done_ff;
  assign done_err = err_ff;
  assign done_rdata = rdata_ff;
  assign link.req_valid = valid_ff;
  assign link.req_write = write_ff;
  assign link.req_port = PORT_ID;
  assign link.req_addr = addr_ff;
  assign link.req_wdata = wdata_ff;

endmodule : fdc_initiator

/* File: bench/fdc_props.sv */
// link checker: timing relations between the two ends of the fabric link
`timescale 1ns/100ps
module fdc_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fic_tick,
  input wire logic [1:0] bus_mode,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_port,
  input wire logic [fdc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [fdc_pkg::DATA_W-1:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_port
);
  import fdc_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic take;
  logic port_ff;
  assign take = fic_tick && req_valid && req_ready;
  // remember the asker, the answer has to find its way back to it
  always_ff @(posedge aclk) begin
    if (take) begin
      port_ff <= req_port;
    end
  end
  chk_take_drops_ready: assert property (take |=> !req_ready)
    else $error("ready high after take");
  chk_no_early_rsp: assert property (take |=> !rsp_valid)
    else $error("answer too early");
  chk_rsp_on_tick: assert property ($rose(rsp_valid) |-> $past(fic_tick))
    else $error("answer off tick");
  chk_rsp_one_tick: assert property (rsp_valid && fic_tick |=> !rsp_valid)
    else $error("answer too long");
  chk_rsp_port_echo: assert property (rsp_valid |-> rsp_port == port_ff)
    else $error("answer to wrong port");
  chk_req_on_tick: assert property ($rose(req_valid) |-> $past(fic_tick))
    else $error("request off tick");
  chk_req_held: assert property (req_valid && !take |=> req_valid && $stable(req_addr))
    else $error("request dropped early");
  chk_ahb_upper_zero: assert property (req_valid && bus_mode != 2'h0
    |-> req_wdata[63:32] == 32'h0) else $error("upper half used");
  chk_mode_legal: assert property (bus_mode != 2'h3)
    else $error("bad bus mode");
  cover property (take);
  cover property (rsp_valid && rsp_port);
  cover property (req_valid && bus_mode == 2'h2);
endmodule : fdc_props

/* File: bench/testbench.sv */
// self-checking bench: register bus, fabric commands and a memory responder
`timescale 1ns/100ps
module testbench;
  import fdc_pkg::*;
  localparam logic [63:0] PAT = 64'hA5A5_0F0F_1234_5678;
  localparam logic [63:0] WPAT = 64'hDEAD_BEEF_CAFE_F00D;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, mem_addr, seen_addr;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, mem_type, mem_width;
  logic fabric_clock_locked_in = 1'h0, clock_synth_locked = 1'h0;
  logic mem_ecc_en, mem_req, mem_we, seen_we, irq, mem_ack = 1'h0;
  logic ecc_one = 1'h0, ecc_two = 1'h0;
  logic [63:0] mem_wdata, seen_wd, done_rdata, cmd_wdata = 64'h0;
  logic [4:0] irq_lines;
  logic cmd_valid = 1'h0, cmd_write = 1'h0, cmd_ready, done, done_err;
  logic [31:0] cmd_addr = 32'h0;
  int n_errors = 0, n_tests = 0;

  always #2 aclk = ~aclk;

  fdc_link_if #(.DATA_W(64), .ADDR_W(32)) lnk (.aclk);
  // short calibration keeps the run brief
  fdc_ctrl #(.CAL_CYCLES(20)) u_fdc_ctrl (.aclk, .aresetn, .link(lnk), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fabric_clock_locked_in, .clock_synth_locked, .mem_type, .mem_width, .mem_ecc_en,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata(PAT),
    .mem_ecc_single(ecc_one), .mem_ecc_double(ecc_two), .irq_lines, .irq);
  // port id 1 so a lost echo cannot pass as the reset value
  fdc_initiator #(.PORT_ID(1'h1)) u_fdc_initiator (.aclk, .aresetn, .link(lnk), .cmd_valid,
    .cmd_ready, .cmd_write, .cmd_addr, .cmd_wdata, .done, .done_err, .done_rdata);
  fdc_props u_fdc_props (.aclk, .aresetn, .fic_tick(lnk.fic_tick), .bus_mode(lnk.bus_mode),
    .req_valid(lnk.req_valid), .req_ready(lnk.req_ready), .req_port(lnk.req_port),
    .req_addr(lnk.req_addr), .req_wdata(lnk.req_wdata), .rsp_valid(lnk.rsp_valid),
    .rsp_port(lnk.rsp_port));

  // memory acks one cycle after each request and keeps what it was asked
  always @(posedge aclk) begin
    mem_ack <= mem_req && !mem_ack;
    if (mem_req && !mem_ack) begin
      seen_we <= mem_we;
      seen_addr <= mem_addr;
      seen_wd <= mem_wdata;
    end
  end

  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // a timed-out wait shows up as response code 1, which is never expected
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit hit = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int i = 0; i < 100 && !hit; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      hit = s_axi_bvalid;
    end
    s_axi_bready <= 1'h0;
    cmp("bresp", er, hit ? s_axi_bresp : 2'h1);
    if (!hit) tally_and_finish();
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit hit = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int i = 0; i < 100 && !hit; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      hit = s_axi_rvalid;
    end
    s_axi_rready <= 1'h0;
    cmp("rresp", er, hit ? s_axi_rresp : 2'h1);
    cmp("rdata", d, s_axi_rdata);
    if (!hit) tally_and_finish();
  endtask : axr

  task automatic cmd(input logic w, input logic [31:0] a);
    bit hit = 1'h0;
    @(posedge aclk);
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= WPAT;
    cmd_valid <= 1'h1;
    for (int i = 0; i < 300 && !hit; i++) begin
      @(posedge aclk);
      hit = cmd_ready;
    end
    cmd_valid <= 1'h0;
    cmp("cmd_ready", 64'h1, hit);
    if (!hit) tally_and_finish();
    hit = 1'h0;
    for (int i = 0; i < 300 && !hit; i++) begin
      @(posedge aclk);
      hit = done;
    end
    cmp("done", 64'h1, hit);
    if (!hit) tally_and_finish();
  endtask : cmd

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    logic [63:0] msk;
    logic [1:0] m;
    repeat (3) @(posedge aclk);
    fabric_clock_locked_in <= 1'h1; // lock settles while reset still holds
    @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    cmp("mem_type", FDC_DDR3, mem_type);
    cmp("mem_width", FDC_W32, mem_width);
    axr(OFS_CTRL, CTRL_RST, RESP_OKAY);
    axr(OFS_FREQ, FREQ_RST_KHZ, RESP_OKAY);
    axr(8'h18, 32'h0, RESP_SLVERR);
    axw(OFS_FAB, 32'h0, RESP_SLVERR);
    axw(OFS_FREQ, 32'h0000_0005, RESP_OKAY);
    axr(OFS_FREQ, FREQ_MIN_KHZ, RESP_OKAY);
    axw(OFS_FREQ, 32'h0001_E240, RESP_OKAY);
    // every memory kind, width and bus option, divisor 1 to 3
    for (int i = 0; i < 3; i++) begin
      m = i[1:0];
      axw(OFS_CTRL, {18'h0, m, 4'(i + 1), 3'h0, i[0], m, m}, RESP_OKAY);
      cmp("mem_type", m, mem_type);
      cmp("mem_width", m, mem_width);
      cmp("mem_ecc_en", i[0], mem_ecc_en);
      cmp("bus_mode", m, lnk.bus_mode);
      axr(OFS_FAB, 32'h0001_E240 / (i + 1), RESP_OKAY);
      msk = (i == 0) ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
      cmd(1'h1, 32'h0000_0100 + 32'(i * 8));
      cmp("mem_we", 64'h1, seen_we);
      cmp("mem_addr", 32'h0000_0100 + 32'(i * 8), seen_addr);
      cmp("mem_wdata", WPAT & msk, seen_wd);
      cmd(1'h0, 32'h0000_0200);
      cmp("done_err", 64'h0, done_err);
      cmp("done_rdata", PAT & msk, done_rdata & msk);
    end
    axw(OFS_MASK, 32'h0000_001F, RESP_OKAY);
    cmd(1'h0, 32'h1000_0000);
    cmp("done_err", 64'h1, done_err);
    cmp("irq", 64'h0, irq);
    axr(OFS_STAT, 32'h1, RESP_OKAY);
    axr(OFS_STAT, 32'h0, RESP_OKAY);
    axw(OFS_CTRL, 32'h0000_0230, RESP_OKAY);
    ecc_two <= 1'h1;
    cmd(1'h0, 32'h0000_0008);
    ecc_two <= 1'h0;
    cmp("done_err", 64'h1, done_err);
    repeat (2) @(posedge aclk);
    cmp("irq_lines", 64'h11, irq_lines);
    cmp("irq", 64'h1, irq);
    axw(OFS_MASK, 32'h0000_0000, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp("irq", 64'h0, irq);
    axr(OFS_STAT, 32'h11, RESP_OKAY);
    axw(OFS_MASK, 32'h0000_001F, RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp("irq", 64'h0, irq);
    ecc_one <= 1'h1;
    cmd(1'h0, 32'h0000_0008);
    ecc_one <= 1'h0;
    cmp("done_err", 64'h0, done_err);
    axr(OFS_STAT, 32'h10, RESP_OKAY);
    axw(OFS_RECAL, 32'h1, RESP_OKAY);
    axr(OFS_RECAL, 32'h1, RESP_OKAY);
    repeat (30) @(posedge aclk);
    axr(OFS_STAT, 32'h2, RESP_OKAY);
    clock_synth_locked <= 1'h1;
    repeat (3) @(posedge aclk);
    axr(OFS_STAT, 32'h4, RESP_OKAY);
    axr(OFS_RECAL, 32'h2, RESP_OKAY);
    clock_synth_locked <= 1'h0;
    repeat (3) @(posedge aclk);
    axr(OFS_STAT, 32'h8, RESP_OKAY);
    // a request waits at the link while the fabric clock is unlocked
    axw(OFS_CTRL, 32'h0000_0240, RESP_OKAY);
    fabric_clock_locked_in <= 1'h0;
    fork
      cmd(1'h0, 32'h0000_0010);
      begin
        repeat (20) @(posedge aclk);
        cmp("req_ready", 64'h0, lnk.req_ready);
        cmp("mem_req", 64'h0, mem_req);
        fabric_clock_locked_in <= 1'h1;
      end
    join
    tally_and_finish();
  end
endmodule : testbench
